// [shared/plc_pkg.sv]
package plc_pkg;
  localparam int CLK_MHZ = 250;

  // line current code: lsb 0.25 uA
  localparam logic [7:0] CUR_LOW = 8'h0A;
  localparam logic [7:0] CUR_BO = 8'h14;
  localparam logic [7:0] CUR_BI = 8'h17;

  // voltage codes: lsb 5 mV
  localparam logic [9:0] V_COMP_ZERO = 10'h2BC;
  localparam logic [9:0] V_COMP_MAX = 10'h182;
  localparam logic [9:0] V_BOOST_HBC = 10'h1CC;
  localparam logic [9:0] V_BOOST_REG = 10'h1F4;

  // consecutive low thermistor samples before tripping
  localparam logic [2:0] OTP_CNT_LAST = 3'h3;

  // times in their own units, cycles derived
  localparam int T_OFF_NS = 1550;
  localparam int T_OFF_CYC = (T_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int F_MAX_KHZ = 134;
  localparam int T_PER_CYC = (CLK_MHZ * 1000 + F_MAX_KHZ - 1) / F_MAX_KHZ;
  localparam int T_VAL_NS = 44500;
  localparam int T_VAL_CYC = T_VAL_NS * CLK_MHZ / 1000;
  localparam int T_BO_MS = 50;
  localparam int T_BO_CYC = T_BO_MS * CLK_MHZ * 1000;

  // on-time gain; 16 from squared current lsb, 200 codes per volt
  localparam int ONT_GAIN = 460;
  localparam int ONT_K = ONT_GAIN * 16 * CLK_MHZ / 200;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_PEAK = 8'h08;
  localparam logic [7:0] REG_TON = 8'h0C;

  typedef struct packed {
    logic xcap_en;
    logic pfc_en;
  } plc_ctrl_t;

  localparam plc_ctrl_t CTRL_RST = 2'h3;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [2:0] otp_cnt;
    logic hbc_en;
    logic otp;
    logic undervoltage_protect;
    logic phase_otp;
    logic gate;
    logic [2:0] run_state;
  } plc_status_t;

  typedef struct packed {
    logic [7:0] line_sense_pin;
    logic [9:0] loop_comp_pin;
    logic [9:0] boost_sense_pin;
  } plc_sense_t;

  typedef enum logic [2:0] {
    PLC_OFF = 3'h1,
    PLC_RUN = 3'h2,
    PLC_SSTOP = 3'h4
  } plc_run_t;

  typedef enum logic [1:0] {
    PH_MAINS = 2'h1,
    PH_OTP = 2'h2
  } plc_phase_t;

  typedef enum logic [3:0] {
    G_IDLE = 4'h1,
    G_ON = 4'h2,
    G_OFF = 4'h4,
    G_VAL = 4'h8
  } plc_gate_t;
endpackage

// [verilog/plc_timer.sv]
`timescale 1ns/10ps
module plc_timer #(
  parameter int W = 24
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [W-1:0] len_i,
  output logic done_o
);
  logic [W-1:0] cnt_reg;

  // dropping run_i clears the count at once
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_reg <= '0;
    end else if (!done_o) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign done_o = run_i && (cnt_reg >= len_i - 1'b1);
endmodule

// [verilog/plc_ontime.sv]
`timescale 1ns/10ps
module plc_ontime import plc_pkg::*; (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // operands
  input wire logic [9:0] comp_i,
  input wire logic [7:0] peak_i,
  // on-time in clock cycles
  output logic [15:0] ton_o
);
  logic [9:0] c_eff;
  logic [23:0] num;
  logic [15:0] den;
  logic [16:0] rem_sh;
  logic [23:0] quo_reg;
  logic [15:0] rem_reg;
  logic [15:0] den_reg;
  logic [4:0] bit_reg;

  always_comb begin
    c_eff = (comp_i < V_COMP_MAX) ? V_COMP_MAX : comp_i;
    num = (comp_i >= V_COMP_ZERO) ? 24'h0 : 24'(ONT_K * int'(V_COMP_ZERO - c_eff));
    den = 16'(peak_i) * 16'(peak_i);
    rem_sh = {rem_reg, quo_reg[23]};
  end

  // serial divider, one result every 25 cycles; slow but the loop is slower
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quo_reg <= 24'h0;
      rem_reg <= 16'h0;
      den_reg <= 16'h0;
      bit_reg <= 5'h0;
      ton_o <= 16'h0;
    end else if (bit_reg == 5'h0) begin
      if (den_reg == 16'h0) begin
        ton_o <= 16'h0;
      end else if (quo_reg[23:16] != 8'h0) begin
        ton_o <= 16'hFFFF;
      end else begin
        ton_o <= quo_reg[15:0];
      end
      quo_reg <= num;
      rem_reg <= 16'h0;
      den_reg <= den;
      bit_reg <= 5'h18;
    end else begin
      if (rem_sh >= {1'b0, den_reg}) begin
        rem_reg <= 16'(rem_sh - {1'b0, den_reg});
        quo_reg <= {quo_reg[22:0], 1'b1};
      end else begin
        rem_reg <= rem_sh[15:0];
        quo_reg <= {quo_reg[22:0], 1'b0};
      end
      bit_reg <= bit_reg - 5'h1;
    end
  end
endmodule

// [verilog/plc_top.sv]
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - line sense pin alternates: mains half cycle, then thermistor half cycle.
// - clamp the line sense pin at 250 mV during mains measurement.
// - track mains current, store its peak once per measurement half cycle.
// - current below 2.5 uA ends mains phase, starts thermistor phase.
// - instantaneous current drives brown-in/out; stored peak drives on-time.
// - mains information starts and stops X-cap discharge and latch reset.
// - current reaching 5.75 uA declares brown-in and starts switching.
// - below 5 uA for a full 50 ms triggers undervoltage stop.
// - thermistor phase enables 200 uA source, then samples pin voltage.
// - over-temperature trips after four consecutive samples below 2 V.
// - valley switching, never above 134 kHz.
// - boost starts first; resonant stage enabled at boost sense 2.3 V.
// - on-time constant over each half sine; no phase angle measured.
// - regulation holds boost sense pin at 2.5 V.
// - comp 3.5 V gives zero on-time, 1.93 V or less maximum.
// - on-time us = 460 * (3.5 V - comp) / peak uA squared.
// - above 134 kHz skip to a later valley.
// - switch off-time never shorter than 1.55 us.
// - no valley within 44.5 us after demagnetization forces switch on.
// - soft stop disconnects amplifier, ends when comp reaches 3.5 V.
module plc_top import plc_pkg::*; #(
  parameter int T_BO_LEN = T_BO_CYC,
  parameter int T_VAL_LEN = T_VAL_CYC
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sensing
  input wire plc_sense_t sense_i,
  input wire logic half_cycle_i,
  input wire logic ntc_low_i,
  input wire logic aux_winding_sense_demag_i,
  input wire logic aux_winding_sense_valley_i,
  input wire logic burst_stop_i,
  // line sense pin sources
  output logic line_clamp_en_o,
  output logic otp_src_en_o,
  // power stage
  output logic boost_gate_out_o,
  output logic resonant_half_bridge_en_o,
  output logic ea_disconnect_o,
  output logic softstop_src_o,
  output logic ea_more_on_o,
  output logic ea_less_on_o,
  // protection
  output logic undervoltage_protect_o,
  output logic otp_o,
  output logic xcap_discharge_o,
  output logic latch_reset_o
);
  plc_phase_t phase_reg;
  plc_run_t run_reg;
  plc_gate_t gate_reg;
  plc_ctrl_t ctrl_reg;
  plc_status_t stat;
  logic [7:0] trk_max_reg;
  logic [7:0] peak_reg;
  logic below_reg;
  logic mains_ok_reg;
  logic bo_done;
  logic mains_end;
  logic [2:0] otp_cnt_reg;
  logic otp_reg;
  logic hbc_reg;
  logic xcap_reg;
  logic latch_rst_reg;
  logic [15:0] ton;
  logic [15:0] ton_lat_reg;
  logic [15:0] on_cnt_reg;
  logic [8:0] off_cnt_reg;
  logic [11:0] per_cnt_reg;
  logic off_done;
  logic per_ok;
  logic sw_ok;
  logic vto;
  logic start_on;
  logic wb_req;
  logic wb_ack_reg;

  wire [7:0] cur = sense_i.line_sense_pin;

  // ends on the drop after the peak, or at the boundary if no drop came first
  assign mains_end = (phase_reg == PH_MAINS) &&
    ((trk_max_reg >= CUR_LOW && cur < CUR_LOW) || half_cycle_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= PH_MAINS;
      trk_max_reg <= 8'h0;
      peak_reg <= 8'h0;
    end else begin
      unique case (phase_reg)
        PH_MAINS: begin
          if (mains_end) begin
            phase_reg <= PH_OTP;
            peak_reg <= trk_max_reg;
            trk_max_reg <= 8'h0;
          end else if (cur > trk_max_reg) begin
            trk_max_reg <= cur;
          end
        end
        PH_OTP: begin
          if (half_cycle_i) begin
            phase_reg <= PH_MAINS;
          end
        end
      endcase
    end
  end

  assign line_clamp_en_o = (phase_reg == PH_MAINS);
  assign otp_src_en_o = (phase_reg == PH_OTP);

  // below level holds through the thermistor half cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      below_reg <= 1'b1;
    end else if (phase_reg == PH_MAINS) begin
      below_reg <= (cur < CUR_BO);
    end
  end

  plc_timer #(.W(24)) u_bo_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(mains_ok_reg && below_reg),
    .len_i(24'(T_BO_LEN)),
    .done_o(bo_done)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mains_ok_reg <= 1'b0;
    end else if (bo_done) begin
      mains_ok_reg <= 1'b0;
    end else if (phase_reg == PH_MAINS && cur >= CUR_BI) begin
      mains_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_rst_reg <= 1'b0;
      xcap_reg <= 1'b0;
    end else begin
      latch_rst_reg <= bo_done && mains_ok_reg;
      xcap_reg <= !mains_ok_reg && ctrl_reg.xcap_en;
    end
  end

  // latch reset on mains loss also releases the thermistor trip; a sample in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      otp_cnt_reg <= 3'h0;
      otp_reg <= 1'b0;
    end else if (phase_reg == PH_OTP && half_cycle_i) begin
      if (!ntc_low_i) begin
        otp_cnt_reg <= 3'h0;
      end else if (otp_cnt_reg == OTP_CNT_LAST) begin
        otp_reg <= 1'b1;
      end else begin
        otp_cnt_reg <= otp_cnt_reg + 3'h1;
      end
    end else if (latch_rst_reg) begin
      otp_cnt_reg <= 3'h0;
      otp_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= PLC_OFF;
    end else begin
      unique case (run_reg)
        PLC_OFF: begin
          if (mains_ok_reg && !otp_reg && ctrl_reg.pfc_en && !burst_stop_i) begin
            run_reg <= PLC_RUN;
          end
        end
        PLC_RUN: begin
          if (!mains_ok_reg || otp_reg) begin
            run_reg <= PLC_OFF;
          end else if (burst_stop_i || !ctrl_reg.pfc_en) begin
            run_reg <= PLC_SSTOP;
          end
        end
        PLC_SSTOP: begin
          if (!mains_ok_reg || otp_reg || sense_i.loop_comp_pin >= V_COMP_ZERO) begin
            run_reg <= PLC_OFF;
          end
        end
      endcase
    end
  end

  assign ea_disconnect_o = (run_reg == PLC_SSTOP);
  assign softstop_src_o = (run_reg == PLC_SSTOP);
  assign ea_more_on_o = (run_reg == PLC_RUN) && (sense_i.boost_sense_pin < V_BOOST_REG);
  assign ea_less_on_o = (run_reg == PLC_RUN) && (sense_i.boost_sense_pin > V_BOOST_REG);

  // resonant stage stays on once enabled, until mains is lost
  always_ff @(posedge clk_i) begin
    if (rst_i || !mains_ok_reg) begin
      hbc_reg <= 1'b0;
    end else if (run_reg == PLC_RUN && sense_i.boost_sense_pin >= V_BOOST_HBC) begin
      hbc_reg <= 1'b1;
    end
  end

  // peak changes once per mains half cycle, so on-time stays flat over the sine
  plc_ontime u_ontime (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .comp_i(sense_i.loop_comp_pin),
    .peak_i(peak_reg),
    .ton_o(ton)
  );

  assign sw_ok = (run_reg != PLC_OFF);
  assign off_done = (off_cnt_reg >= 9'(T_OFF_CYC - 1));
  assign per_ok = (per_cnt_reg >= 12'(T_PER_CYC - 1));
  assign start_on = per_ok && (aux_winding_sense_valley_i || vto);

  plc_timer #(.W(16)) u_val_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(gate_reg == G_VAL || (gate_reg == G_OFF && off_done && !aux_winding_sense_demag_i)),
    .len_i(16'(T_VAL_LEN)),
    .done_o(vto)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_reg <= G_IDLE;
      ton_lat_reg <= 16'h0;
    end else begin
      unique case (gate_reg)
        G_IDLE: begin
          if (sw_ok && per_ok && ton != 16'h0) begin
            gate_reg <= G_ON;
            ton_lat_reg <= ton;
          end
        end
        G_ON: begin
          if (!sw_ok || on_cnt_reg >= ton_lat_reg - 16'h1) begin
            gate_reg <= G_OFF;
          end
        end
        G_OFF: begin
          if (off_done) begin
            if (!sw_ok) begin
              gate_reg <= G_IDLE;
            end else if (aux_winding_sense_demag_i) begin
              gate_reg <= G_VAL;
            end else if (vto) begin
              gate_reg <= G_VAL;
            end
          end
        end
        G_VAL: begin
          if (!sw_ok) begin
            gate_reg <= G_IDLE;
          end else if (start_on) begin
            if (ton != 16'h0) begin
              gate_reg <= G_ON;
              ton_lat_reg <= ton;
            end else begin
              gate_reg <= G_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || gate_reg != G_ON) begin
      on_cnt_reg <= 16'h0;
    end else begin
      on_cnt_reg <= on_cnt_reg + 16'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || gate_reg != G_OFF) begin
      off_cnt_reg <= 9'h0;
    end else if (!off_done) begin
      off_cnt_reg <= off_cnt_reg + 9'h1;
    end
  end

  // period since last turn-on; starts satisfied after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_cnt_reg <= 12'hFFF;
    end else if (gate_reg != G_ON && boost_gate_out_next()) begin
      per_cnt_reg <= 12'h0;
    end else if (per_cnt_reg != 12'hFFF) begin
      per_cnt_reg <= per_cnt_reg + 12'h1;
    end
  end

  function automatic logic boost_gate_out_next();
    boost_gate_out_next = (gate_reg == G_IDLE && sw_ok && per_ok && ton != 16'h0) ||
      (gate_reg == G_VAL && sw_ok && start_on && ton != 16'h0);
  endfunction

  assign boost_gate_out_o = (gate_reg == G_ON);
  assign resonant_half_bridge_en_o = hbc_reg;
  assign undervoltage_protect_o = !mains_ok_reg;
  assign otp_o = otp_reg;
  assign xcap_discharge_o = xcap_reg;
  assign latch_reset_o = latch_rst_reg;

  // wishbone: ack one cycle after request, writes land at the ack edge
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_ack_o = wb_ack_reg;

  always_comb begin
    stat = '0;
    stat.otp_cnt = otp_cnt_reg;
    stat.hbc_en = hbc_reg;
    stat.otp = otp_reg;
    stat.undervoltage_protect = !mains_ok_reg;
    stat.phase_otp = (phase_reg == PH_OTP);
    stat.gate = boost_gate_out_o;
    stat.run_state = run_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_reg <= wb_req && !wb_ack_reg;
      if (wb_req && !wb_ack_reg) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= {30'h0, ctrl_reg};
          REG_STAT: wb_dat_o <= stat;
          REG_PEAK: wb_dat_o <= {24'h0, peak_reg};
          REG_TON: wb_dat_o <= {16'h0, ton_lat_reg};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (wb_req && wb_we_i && wb_ack_reg && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      ctrl_reg <= wb_dat_i[1:0];
    end
  end

  // helper counters for the checks below
  logic [11:0] off_len_reg;
  logic [11:0] per_len_reg;
  logic gate_q_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_len_reg <= 12'hFFF;
      per_len_reg <= 12'hFFF;
      gate_q_reg <= 1'b0;
    end else begin
      gate_q_reg <= boost_gate_out_o;
      if (boost_gate_out_o) begin
        off_len_reg <= 12'h0;
      end else if (off_len_reg != 12'hFFF) begin
        off_len_reg <= off_len_reg + 12'h1;
      end
      if (boost_gate_out_o && !gate_q_reg) begin
        per_len_reg <= 12'h1;
      end else if (per_len_reg != 12'hFFF) begin
        per_len_reg <= per_len_reg + 12'h1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_mains_drop;
    phase_reg == PH_MAINS && trk_max_reg >= CUR_LOW && cur < CUR_LOW;
  endsequence

  sequence s_otp_low_last;
    phase_reg == PH_OTP && half_cycle_i && ntc_low_i && otp_cnt_reg == OTP_CNT_LAST;
  endsequence

  sequence s_otp_high;
    phase_reg == PH_OTP && half_cycle_i && !ntc_low_i;
  endsequence

  AST_MAINS_TO_OTP: assert property (s_mains_drop |=> otp_src_en_o && !line_clamp_en_o)
    else $error("mains phase did not hand over to thermistor phase");
  AST_CLAMP_EXCL: assert property (phase_reg == PH_OTP && half_cycle_i |=>
    line_clamp_en_o && !otp_src_en_o)
    else $error("thermistor phase did not hand back to clamped mains phase");
  AST_PEAK_STORE: assert property (s_mains_drop |=> peak_reg == $past(trk_max_reg))
    else $error("peak not stored at end of mains phase");
  AST_BROWNIN: assert property (phase_reg == PH_MAINS && cur >= CUR_BI && !bo_done |=> mains_ok_reg)
    else $error("brown-in not declared");
  AST_UVP: assert property ($fell(mains_ok_reg) |-> $past(bo_done) && $past(below_reg))
    else $error("undervoltage without expired filter");
  AST_OTP_TRIP: assert property (s_otp_low_last |=> otp_o)
    else $error("fourth low sample did not trip");
  AST_OTP_CLR: assert property (s_otp_high |=> otp_cnt_reg == 3'h0)
    else $error("high sample did not clear counter");
  AST_MIN_OFF: assert property ($rose(boost_gate_out_o) |-> off_len_reg >= 12'(T_OFF_CYC))
    else $error("off-time shorter than minimum");
  AST_FREQ: assert property ($rose(boost_gate_out_o) |-> per_len_reg >= 12'(T_PER_CYC))
    else $error("switching period below frequency ceiling");
  AST_HBC: assert property ($rose(resonant_half_bridge_en_o) |->
    $past(sense_i.boost_sense_pin) >= V_BOOST_HBC && $past(run_reg) == PLC_RUN)
    else $error("resonant stage enabled before boost charged");
  AST_SSTOP_END: assert property (run_reg == PLC_SSTOP && sense_i.loop_comp_pin >= V_COMP_ZERO
    |=> run_reg == PLC_OFF && !ea_disconnect_o)
    else $error("soft stop did not end at zero on-time level");
endmodule

// [test/plc_far_model.sv]
`timescale 1ns/10ps
module plc_far_model #(
  parameter int DEMAG_CYC = 100
) (
  // system
  input wire logic clk_i,
  // from the block
  input wire logic gate_i,
  input wire logic otp_src_en_i,
  // scenario controls
  input wire logic valley_on_i,
  input wire logic ntc_hot_i,
  // comparator results
  output logic demag_o,
  output logic valley_o,
  output logic ntc_low_o
);
  logic [15:0] cnt_reg = 16'h0000;

  // cycles since the switch opened; saturates so a long stop stays demagnetized
  always @(posedge clk_i) begin
    if (gate_i) cnt_reg <= 16'h0000;
    else if (cnt_reg != 16'hFFFF) cnt_reg <= cnt_reg + 16'h0001;
  end

  // coil still delivers current for a while, then the drain rings
  assign demag_o = !gate_i && cnt_reg >= DEMAG_CYC;
  assign valley_o = demag_o && valley_on_i && cnt_reg[4:0] == 5'h1F;
  // comparator means nothing with the source off, so keep it moving
  assign ntc_low_o = otp_src_en_i ? ntc_hot_i : cnt_reg[0];
endmodule

// [test/testbench.sv]
`timescale 1ns/10ps
module testbench import plc_pkg::*; ;
  localparam int T_BO = 1000;
  localparam int T_VAL = 2000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, clamp, src, gate, resonant_half_bridge, ea_dis, more_on, undervoltage_protect, otp_o, xcap, lrst;
  logic half_cycle = 1'b0, burst_stop = 1'b0, valley_on = 1'b1, ntc_hot = 1'b0;
  logic demag, valley, ntc_low, ss_src, less_on;
  plc_sense_t sense = '0;
  logic [15:0] rnd = 16'h0063;
  int num_errors = 0;
  int compares = 0;

  plc_top #(.T_BO_LEN(T_BO), .T_VAL_LEN(T_VAL)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sense_i(sense), .half_cycle_i(half_cycle), .ntc_low_i(ntc_low),
    .aux_winding_sense_demag_i(demag), .aux_winding_sense_valley_i(valley),
    .burst_stop_i(burst_stop), .line_clamp_en_o(clamp), .otp_src_en_o(src),
    .boost_gate_out_o(gate), .resonant_half_bridge_en_o(resonant_half_bridge), .ea_disconnect_o(ea_dis),
    .softstop_src_o(ss_src), .ea_more_on_o(more_on), .ea_less_on_o(less_on),
    .undervoltage_protect_o(undervoltage_protect), .otp_o(otp_o), .xcap_discharge_o(xcap),
    .latch_reset_o(lrst));

  plc_far_model u_far (.clk_i(clk_i), .gate_i(gate), .otp_src_en_i(src),
    .valley_on_i(valley_on), .ntc_hot_i(ntc_hot), .demag_o(demag), .valley_o(valley),
    .ntc_low_o(ntc_low));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // clamp low comp to the maximum point, saturate to the counter width
  function automatic logic [15:0] ton_exp(input int comp, input int peak);
    int v;
    v = comp < V_COMP_MAX ? V_COMP_MAX : comp;
    v = ONT_K * (V_COMP_ZERO - v) / (peak * peak);
    if (comp >= V_COMP_ZERO || peak == 0) v = 0;
    return v > 32'h0000_FFFF ? 16'hFFFF : v[15:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hF;
    wb_adr <= adr;
    wb_dat <= dat;
    @(posedge clk_i);
    // no cycle count assumed; only the watchdog ends a hung wait
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
    @(posedge clk_i);
  endtask

  task automatic wait_gate(input logic val, output int n);
    n = 0;
    while (gate !== val && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic pulse();
    half_cycle <= 1'b1;
    @(posedge clk_i);
    half_cycle <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    num_errors++;
    summarize();
  end

  initial begin
    logic [31:0] rd;
    logic [9:0] comp;
    int hi, lo, n;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({clamp, src, undervoltage_protect, gate}, 4'hA);
    wb(1'b0, REG_CTRL, 32'h0, rd);
    check(rd, 32'h3);
    wb(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    sense <= '{line_sense_pin: 8'h28, loop_comp_pin: 10'h1F4, boost_sense_pin: 10'h190};
    repeat (4) @(posedge clk_i);
    check({undervoltage_protect, resonant_half_bridge, more_on, less_on}, 4'h2);
    wb(1'b0, REG_STAT, 32'h0, rd);
    check(rd[2:0], PLC_RUN);
    sense.line_sense_pin <= 8'h08;
    repeat (3) @(posedge clk_i);
    check({clamp, src}, 2'h1);
    sense.line_sense_pin <= 8'h28;
    repeat (4) @(posedge clk_i);
    check(src, 1'b1);
    wb(1'b0, REG_PEAK, 32'h0, rd);
    check(rd[7:0], 8'h28);
    pulse();
    check({clamp, src}, 2'h2);
    sense.boost_sense_pin <= 10'h1D6;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      comp = i == 0 ? 10'h12C : i == 1 ? 10'h2B2 : 10'h182 + rnd % 16'h013A;
      sense.loop_comp_pin <= comp;
      // first turn-on may still carry the old on-time
      wait_gate(1'b1, n);
      wait_gate(1'b0, n);
      wait_gate(1'b1, n);
      wait_gate(1'b0, hi);
      wait_gate(1'b1, lo);
      check(hi, ton_exp(comp, 8'h28));
      check(lo >= T_OFF_CYC, 1'b1);
      check(hi + lo >= T_PER_CYC, 1'b1);
      wb(1'b0, REG_TON, 32'h0, rd);
      check(rd[15:0], ton_exp(comp, 8'h28));
    end
    check(resonant_half_bridge, 1'b1);
    sense.boost_sense_pin <= 10'h208;
    repeat (2) @(posedge clk_i);
    check({more_on, less_on}, 2'h1);
    valley_on <= 1'b0;
    wait_gate(1'b0, n);
    wait_gate(1'b1, lo);
    check(lo >= T_VAL && lo <= T_VAL + T_OFF_CYC + 120, 1'b1);
    valley_on <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      pulse();
      ntc_hot <= k != 3;
      pulse();
      check(otp_o, k == 7);
    end
    sense.line_sense_pin <= 8'h0F;
    repeat (T_BO / 2) @(posedge clk_i);
    sense.line_sense_pin <= 8'h28;
    repeat (10) @(posedge clk_i);
    sense.line_sense_pin <= 8'h0F;
    n = 0;
    while (undervoltage_protect !== 1'b1 && n < 2 * T_BO) begin
      @(posedge clk_i);
      n++;
    end
    check(lrst, 1'b1);
    check(n >= T_BO && n <= T_BO + 4, 1'b1);
    repeat (3) @(posedge clk_i);
    check({otp_o, gate, xcap}, 3'h1);
    wb(1'b1, REG_CTRL, 32'h1, rd);
    repeat (2) @(posedge clk_i);
    check(xcap, 1'b0);
    sense <= '{line_sense_pin: 8'h28, loop_comp_pin: 10'h1F4, boost_sense_pin: 10'h1D6};
    repeat (6) @(posedge clk_i);
    burst_stop <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({ea_dis, ss_src}, 2'h3);
    sense.loop_comp_pin <= V_COMP_ZERO;
    repeat (4) @(posedge clk_i);
    check({ea_dis, ss_src}, 2'h0);
    wb(1'b0, REG_STAT, 32'h0, rd);
    check(rd[2:0], PLC_OFF);
    burst_stop <= 1'b0;
    summarize();
  end
endmodule
